// [sppr_pkg.sv]
// shared constants and types for the supply pulse programming block
package sppr_pkg;
  // ****************************************
  // clock and timing
  // ****************************************
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned BLOW_TIME_NS = 100000; // least blow pulse length
  localparam int unsigned BLOW_CYCLES = (BLOW_TIME_NS * CLK_MHZ + 999) / 1000;

  // ****************************************
  // programming register space
  // ****************************************
  localparam int unsigned NUM_REGS = 4;
  localparam int unsigned FIELD_W = 8;
  localparam int unsigned FUSE_W = NUM_REGS * FIELD_W;
  localparam logic [1:0] PREG_OUT = 2'h0; // fall time, invert, lock
  localparam logic [1:0] PREG_MAG = 2'h1; // operate point magnitude
  localparam logic [1:0] PREG_SIGN = 2'h2; // operate point sign
  localparam logic [1:0] PREG_CHK = 2'h3; // fuse checking, try only
  localparam int unsigned FALL_LSB = 0;
  localparam int unsigned INVERT_BIT = 2;
  localparam int unsigned LOCK_BIT = 3;
  localparam logic [3:0] BLOW_KEY_MIDS = 4'hb;
  localparam logic [7:0] CODE_AUTO = 8'h01;

  // ****************************************
  // bus register map
  // ****************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_FUSE = 8'h08;
  localparam logic [7:0] ADDR_EFFECT = 8'h0c;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_KEY = 6'h02,
    ST_TRY = 6'h04,
    ST_BLOW = 6'h08,
    ST_READ = 6'h10,
    ST_SPENT = 6'h20
  } sppr_state_t;

  typedef struct packed {
    logic done;
    logic high;
    logic long_hold;
  } sppr_pulse_t;
endpackage : sppr_pkg

// [sppr_pulse_class.sv]
// supply pulse level classifier with synchronised comparators
`timescale 1ns/1ps
module sppr_pulse_class #(
  parameter int unsigned BLOW_CYCLES = sppr_pkg::BLOW_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic level_high_pin,
  input wire logic level_mid_pin,
  output sppr_pkg::sppr_pulse_t pulse_o
);
  localparam int unsigned CW = $clog2(BLOW_CYCLES + 1);
  logic [1:0] meta_reg;
  logic [1:0] sync_reg;
  logic in_pulse_reg;
  logic saw_high_reg;
  logic [CW-1:0] high_cnt_reg;
  sppr_pkg::sppr_pulse_t pulse_reg;

  // two stage synchroniser for both comparators
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= 2'h0;
      sync_reg <= 2'h0;
    end else begin
      meta_reg <= {level_high_pin, level_mid_pin};
      sync_reg <= meta_reg;
    end
  end

  // a pulse lasts while the supply sits above the low level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_pulse_reg <= 1'b0;
      saw_high_reg <= 1'b0;
      high_cnt_reg <= '0;
      pulse_reg <= '0;
    end else begin
      pulse_reg <= '0;
      if (sync_reg != 2'h0) begin
        in_pulse_reg <= 1'b1;
        if (sync_reg[1]) begin
          saw_high_reg <= 1'b1;
          if (high_cnt_reg != CW'(BLOW_CYCLES)) begin
            high_cnt_reg <= high_cnt_reg + CW'(1);
          end
        end
      end else if (in_pulse_reg) begin // back to low: classify [R05] [R21]
        in_pulse_reg <= 1'b0;
        saw_high_reg <= 1'b0;
        high_cnt_reg <= '0;
        pulse_reg.done <= 1'b1;
        pulse_reg.high <= saw_high_reg;
        pulse_reg.long_hold <= high_cnt_reg == CW'(BLOW_CYCLES);
      end
    end
  end

  assign pulse_o = pulse_reg;
endmodule : sppr_pulse_class

// [sppr_top.sv]
// supply pulse programming logic with switch output and bus registers
// Notes on behaviour
// [R01] invert clear: on above operate, off below release
// [R02] invert set: off above operate, on below
// [R03] operate point programmable, threshold gap fixed
// [R04] commands arrive as supply pulse trains
// [R05] each pulse classed high, mid or low
// [R06] trial values volatile, applied at once
// [R07] blow mode sets fuses, lock included
// [R08] read mode reports each fuse bit
// [R09] lock refuses every parameter register
// [R10] fuse checking register stays usable after lock
// [R11] code is binary fuse pattern, lsb code one
// [R12] each addressing pulse increments selected code
// [R13] value live while addressing, permanent after blow
// [R14] long high pulse blows only addressed fuse
// [R15] blown fuse never cleared
// [R16] key: high, mid, then register bits
// [R17] blow key: eleven mids then one high
// [R18] one fuse blown per power cycle
// [R19] read mode output low when fuse blown
// [R20] fall time bits 1:0, invert bit 2
// [R21] synced comparators; unexpected pulse returns initial
// [R22] power-up clears trials; fuses give defaults
`timescale 1ns/1ps
module sppr_top #(
  parameter int unsigned BLOW_CYCLES = sppr_pkg::BLOW_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic level_high_pin,
  input wire logic level_mid_pin,
  input wire logic supply_ok_pin,
  input wire logic field_above_op_pin,
  input wire logic field_below_rp_pin,
  input wire logic [sppr_pkg::FUSE_W-1:0] fuse_sense_pin,
  output logic switch_output,
  output logic [7:0] operate_point_magnitude,
  output logic operate_point_sign,
  output logic [1:0] fall_time,
  output logic [1:0] fuse_check_sel,
  output logic fuse_blow,
  output logic [4:0] fuse_blow_index,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);
  // ****************************************
  // declarations
  // ****************************************
  localparam int unsigned NR = sppr_pkg::NUM_REGS;
  localparam int unsigned FW = sppr_pkg::FIELD_W;
  sppr_pkg::sppr_pulse_t pulse;
  sppr_pkg::sppr_state_t st_reg;
  logic [3:0] pin_meta_reg;
  logic [3:0] pin_sync_reg;
  logic [sppr_pkg::FUSE_W-1:0] fuse_meta_reg;
  logic [sppr_pkg::FUSE_W-1:0] fuse_reg;
  logic [1:0] key_pos_reg;
  logic key_bit_reg;
  logic [1:0] sel_reg;
  logic [7:0] code_reg;
  logic [3:0] mids_reg;
  logic [2:0] addr_reg;
  logic addr_seen_reg;
  logic [FW-1:0] trial_reg [NR];
  logic [NR-1:0] trial_vld_reg;
  logic active_reg;
  logic ctrl_en_reg;
  logic aw_have_reg;
  logic w_have_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic supply_s;
  logic above_s;
  logic below_s;
  logic locked;
  logic invert;
  logic read_bit;

  // effective value: trial when present, else fuse pattern
  function automatic logic [FW-1:0] eff(input logic [1:0] r);
    eff = trial_vld_reg[r] ? trial_reg[r] : fuse_reg[r*FW +: FW]; // [R06] [R22] [R11]
  endfunction : eff

  function automatic logic [31:0] rd_word(input logic [7:0] a);
    case (a)
      sppr_pkg::ADDR_CTRL: rd_word = {31'h0000_0000, ctrl_en_reg};
      sppr_pkg::ADDR_STATUS: rd_word = {11'h000, trial_vld_reg, locked, code_reg, sel_reg, st_reg};
      sppr_pkg::ADDR_FUSE: rd_word = fuse_reg;
      sppr_pkg::ADDR_EFFECT: rd_word = {eff(2'h3), eff(2'h2), eff(2'h1), eff(2'h0)};
      default: rd_word = 32'h0000_0000;
    endcase
  endfunction : rd_word

  // ****************************************
  // pin synchronisers and pulse classifier
  // ****************************************
  sppr_pulse_class #(.BLOW_CYCLES(BLOW_CYCLES)) u_class (
    .aclk(aclk),
    .aresetn(aresetn),
    .level_high_pin(level_high_pin),
    .level_mid_pin(level_mid_pin),
    .pulse_o(pulse)
  );

  // two flops on every pin input
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_reg <= 4'h0;
      pin_sync_reg <= 4'h0;
      fuse_meta_reg <= '0;
      fuse_reg <= '0;
    end else begin
      pin_meta_reg <= {supply_ok_pin, field_above_op_pin, field_below_rp_pin, 1'b0};
      pin_sync_reg <= pin_meta_reg;
      fuse_meta_reg <= fuse_sense_pin;
      fuse_reg <= fuse_meta_reg; // [R21]
    end
  end

  assign supply_s = pin_sync_reg[3];
  assign above_s = pin_sync_reg[2];
  assign below_s = pin_sync_reg[1];
  assign locked = fuse_reg[sppr_pkg::LOCK_BIT];
  assign invert = 1'(eff(sppr_pkg::PREG_OUT) >> sppr_pkg::INVERT_BIT); // [R20]
  assign read_bit = fuse_reg[{sel_reg, addr_reg}];

  // ****************************************
  // key decoder and mode sequencer
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn || !supply_s || !ctrl_en_reg) begin // [R21] [R22]
      st_reg <= sppr_pkg::ST_IDLE;
      key_pos_reg <= 2'h0;
      key_bit_reg <= 1'b0;
      sel_reg <= 2'h0;
      code_reg <= 8'h00;
      mids_reg <= 4'h0;
      addr_reg <= 3'h0;
      addr_seen_reg <= 1'b0;
    end else if (pulse.done) begin // [R04]
      case (st_reg)
        sppr_pkg::ST_IDLE: begin
          key_pos_reg <= 2'h0;
          if (pulse.high) begin
            st_reg <= sppr_pkg::ST_KEY; // [R16]
          end
        end
        sppr_pkg::ST_KEY: begin
          key_pos_reg <= key_pos_reg + 2'h1;
          if (key_pos_reg == 2'h0 && pulse.high) begin
            st_reg <= sppr_pkg::ST_IDLE; // second key pulse must be mid
          end else if (key_pos_reg == 2'h1) begin
            key_bit_reg <= pulse.high;
          end else if (key_pos_reg == 2'h2) begin
            sel_reg <= {key_bit_reg, pulse.high}; // [R16]
            code_reg <= sppr_pkg::CODE_AUTO;
            mids_reg <= 4'h0;
            if (locked && {key_bit_reg, pulse.high} != sppr_pkg::PREG_CHK) begin
              st_reg <= sppr_pkg::ST_IDLE; // [R09]
            end else begin
              st_reg <= sppr_pkg::ST_TRY; // [R10]
            end
          end
        end
        sppr_pkg::ST_TRY: begin
          if (!pulse.high) begin
            code_reg <= code_reg + 8'h01; // [R12]
            if (mids_reg != 4'hf) begin
              mids_reg <= mids_reg + 4'h1;
            end
          end else if (mids_reg == sppr_pkg::BLOW_KEY_MIDS && sel_reg != sppr_pkg::PREG_CHK) begin
            st_reg <= sppr_pkg::ST_BLOW; // [R17]
            addr_reg <= 3'h0;
            addr_seen_reg <= 1'b0;
          end else begin
            st_reg <= sppr_pkg::ST_IDLE; // [R21]
          end
        end
        sppr_pkg::ST_BLOW: begin
          if (!pulse.high) begin
            addr_reg <= addr_reg + 3'h1; // binary bit address
            addr_seen_reg <= 1'b1;
          end else if (pulse.long_hold) begin
            st_reg <= sppr_pkg::ST_SPENT; // [R07] [R18]
          end else if (!addr_seen_reg) begin
            st_reg <= sppr_pkg::ST_READ; // [R08]
          end else begin
            st_reg <= sppr_pkg::ST_IDLE;
          end
        end
        sppr_pkg::ST_READ: begin
          if (!pulse.high) begin
            addr_reg <= addr_reg + 3'h1; // [R08]
          end else begin
            st_reg <= sppr_pkg::ST_IDLE;
          end
        end
        sppr_pkg::ST_SPENT: begin
          st_reg <= sppr_pkg::ST_SPENT; // wait for power cycle
        end
        default: begin
          st_reg <= sppr_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // volatile trial values
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn || !supply_s) begin // [R22]
      trial_vld_reg <= '0;
      for (int i = 0; i < NR; i++) begin
        trial_reg[i] <= '0;
      end
    end else if (pulse.done && ctrl_en_reg) begin
      if (st_reg == sppr_pkg::ST_KEY && key_pos_reg == 2'h2) begin
        if (!locked || {key_bit_reg, pulse.high} == sppr_pkg::PREG_CHK) begin
          trial_vld_reg[{key_bit_reg, pulse.high}] <= 1'b1; // [R06]
          trial_reg[{key_bit_reg, pulse.high}] <= sppr_pkg::CODE_AUTO;
        end
      end else if (st_reg == sppr_pkg::ST_TRY && !pulse.high) begin
        trial_reg[sel_reg] <= code_reg + 8'h01; // [R13]
      end
    end
  end

  // ****************************************
  // fuse blow strobe and parameter outputs
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fuse_blow <= 1'b0;
      fuse_blow_index <= 5'h00;
      operate_point_magnitude <= 8'h00;
      operate_point_sign <= 1'b0;
      fall_time <= 2'h0;
      fuse_check_sel <= 2'h0;
    end else begin
      fuse_blow <= st_reg == sppr_pkg::ST_BLOW && pulse.done && pulse.high
        && pulse.long_hold && ctrl_en_reg && supply_s; // [R14] [R15]
      fuse_blow_index <= {sel_reg, addr_reg}; // [R14]
      operate_point_magnitude <= eff(sppr_pkg::PREG_MAG); // [R03] [R13]
      operate_point_sign <= 1'(eff(sppr_pkg::PREG_SIGN));
      fall_time <= 2'(eff(sppr_pkg::PREG_OUT) >> sppr_pkg::FALL_LSB); // [R20]
      fuse_check_sel <= trial_vld_reg[sppr_pkg::PREG_CHK] ? 2'(eff(sppr_pkg::PREG_CHK)) : 2'h0; // [R10]
    end
  end

  // ****************************************
  // switch output with fixed hysteresis
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_reg <= 1'b0;
      switch_output <= 1'b1;
    end else begin
      if (above_s) begin
        active_reg <= 1'b1; // [R01]
      end else if (below_s) begin
        active_reg <= 1'b0;
      end
      if (st_reg == sppr_pkg::ST_READ) begin
        switch_output <= !read_bit; // [R19]
      end else begin
        switch_output <= !(active_reg ^ invert); // [R01] [R02]
      end
    end
  end

  // ****************************************
  // axi4-lite slave
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sppr_pkg::RESP_OKAY;
      ctrl_en_reg <= sppr_pkg::CTRL_RESET[0];
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (aw_have_reg && w_have_reg && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bresp <= awaddr_reg[7:4] == 4'h0 && awaddr_reg[1:0] == 2'h0
          ? sppr_pkg::RESP_OKAY : sppr_pkg::RESP_SLVERR;
        if (awaddr_reg == sppr_pkg::ADDR_CTRL && wstrb_reg[0]) begin
          ctrl_en_reg <= wdata_reg[0];
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // read channel: answer one cycle after address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= sppr_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word(s_axi_araddr);
      s_axi_rresp <= s_axi_araddr[7:4] == 4'h0 && s_axi_araddr[1:0] == 2'h0
        ? sppr_pkg::RESP_OKAY : sppr_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ****************************************
  // assertions and covers
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_switch_plain: assert property ((above_s && !invert && st_reg != sppr_pkg::ST_READ) [*2] // [R01]
    |=> !switch_output) else $error("switch not on above operate");
  chk_switch_invert: assert property ((above_s && invert && st_reg != sppr_pkg::ST_READ) [*2] // [R02]
    |=> switch_output) else $error("inverted switch not off");
  chk_read_out: assert property ((st_reg == sppr_pkg::ST_READ) [*2] // [R19]
    |-> switch_output == !$past(read_bit)) else $error("read output wrong");
  chk_lock_refuse: assert property (locked && st_reg == sppr_pkg::ST_TRY // [R09]
    |-> sel_reg == sppr_pkg::PREG_CHK) else $error("locked register accessed");
  chk_blow_cause: assert property (fuse_blow // [R14]
    |-> $past(st_reg == sppr_pkg::ST_BLOW && pulse.long_hold)) else $error("blow without long pulse");
  chk_blow_once: assert property (fuse_blow |-> st_reg == sppr_pkg::ST_SPENT ##1 !fuse_blow [*4]) // [R18]
    else $error("second blow");
  chk_addr_step: assert property (st_reg == sppr_pkg::ST_TRY && pulse.done && !pulse.high && supply_s // [R12]
    && ctrl_en_reg |=> code_reg == $past(code_reg) + 8'h01) else $error("code not incremented");
  chk_key_start: assert property (st_reg == sppr_pkg::ST_IDLE && pulse.done && !pulse.high // [R16]
    |=> st_reg == sppr_pkg::ST_IDLE) else $error("key began with mid");
  chk_trial_live: assert property (st_reg == sppr_pkg::ST_TRY |-> trial_vld_reg[sel_reg]) // [R06]
    else $error("trial value not applied");
  chk_supply_drop: assert property (!supply_s |=> st_reg == sppr_pkg::ST_IDLE && trial_vld_reg == '0) // [R21]
    else $error("supply drop not cleared");

  cov_blow: cover property (fuse_blow);
  cov_read: cover property (st_reg == sppr_pkg::ST_READ && switch_output == 1'b0);
  cov_try_code: cover property (st_reg == sppr_pkg::ST_TRY && code_reg == 8'h0c);
  cov_lock_chk: cover property (locked && st_reg == sppr_pkg::ST_TRY);
endmodule : sppr_top

// [sppr_prog_model.sv]
// programmer model driving multilevel pulses on the supply pin
`timescale 1ns/1ps
module sppr_prog_model #(
  parameter int unsigned LONG_CYC = 24
) (
  input wire logic aclk,
  output logic level_high_pin,
  output logic level_mid_pin,
  output logic supply_ok_pin
);
  // ****************************************
  // pulse generation
  // ****************************************
  // supply idles at the low level between pulses
  initial begin
    level_high_pin = 1'b0;
    level_mid_pin = 1'b0;
    supply_ok_pin = 1'b1;
  end

  // one pulse: a high pulse also passes the mid level
  task automatic pulse(input logic hi, input int unsigned len);
    @(posedge aclk);
    level_high_pin <= hi;
    level_mid_pin <= 1'b1;
    repeat (len) @(posedge aclk);
    level_high_pin <= 1'b0;
    level_mid_pin <= 1'b0;
    repeat (14) @(posedge aclk); // gap lets the decoder settle
  endtask : pulse

  // register key: high, mid, then the two register bits
  task automatic key(input logic [1:0] r);
    pulse(1'b1, 6);
    pulse(1'b0, 6);
    pulse(r[1], 6);
    pulse(r[0], 6);
  endtask : key

  // addressing pulses, one code step each
  task automatic mids(input int unsigned n);
    repeat (n) pulse(1'b0, 6);
  endtask : mids

  // long high pulse that blows the addressed fuse
  task automatic blow();
    pulse(1'b1, LONG_CYC);
  endtask : blow

  // supply present or cut, power cycling between blows
  task automatic supply(input logic v);
    @(posedge aclk);
    supply_ok_pin <= v;
  endtask : supply
endmodule : sppr_prog_model

// [sppr_top_tb.sv]
// self-checking bench for the supply pulse programming block
`timescale 1ns/1ps
module sppr_top_tb;
  localparam int unsigned BLOW_N = 16;
  localparam logic [1:0] OK = sppr_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = sppr_pkg::RESP_SLVERR;
  logic aclk, aresetn, level_high_pin, level_mid_pin, supply_ok_pin;
  logic field_above_op_pin, field_below_rp_pin, switch_output, operate_point_sign;
  logic [31:0] fuse_sense_pin, s_axi_wdata, s_axi_rdata;
  logic [7:0] operate_point_magnitude, s_axi_awaddr, s_axi_araddr;
  logic [1:0] fall_time, fuse_check_sel, s_axi_bresp, s_axi_rresp;
  logic fuse_blow, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [4:0] fuse_blow_index, blow_last;
  logic [3:0] s_axi_wstrb;
  int bad_count = 0, tests_run = 0, blow_n = 0;

  // ****************************************
  // clock, parts and monitors
  // ****************************************
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  sppr_prog_model #(.LONG_CYC(BLOW_N + 8)) prog (.aclk(aclk), .level_high_pin(level_high_pin),
    .level_mid_pin(level_mid_pin), .supply_ok_pin(supply_ok_pin));

  sppr_top #(.BLOW_CYCLES(BLOW_N)) dut (
    .aclk(aclk), .aresetn(aresetn), .level_high_pin(level_high_pin), .level_mid_pin(level_mid_pin),
    .supply_ok_pin(supply_ok_pin), .field_above_op_pin(field_above_op_pin),
    .field_below_rp_pin(field_below_rp_pin), .fuse_sense_pin(fuse_sense_pin), .switch_output(switch_output),
    .operate_point_magnitude(operate_point_magnitude), .operate_point_sign(operate_point_sign),
    .fall_time(fall_time), .fuse_check_sel(fuse_check_sel), .fuse_blow(fuse_blow),
    .fuse_blow_index(fuse_blow_index), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp));

  // count blow strobes and keep the last index
  always @(posedge aclk) begin
    if (fuse_blow === 1'b1) begin
      blow_n <= blow_n + 1;
      blow_last <= fuse_blow_index;
    end
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    test_done();
  end

  // ****************************************
  // helper tasks
  // ****************************************
  task automatic test_done();
    if (bad_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // bus write; valids drop once taken, bready held until the answer
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask : axw

  // bus read, compares masked data and response
  task automatic axr(input logic [7:0] a, input logic [1:0] er, input logic [31:0] m, input logic [31:0] e);
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    s_axi_rready <= 1'b0;
    chk(32'(s_axi_rresp), 32'(er));
    chk(s_axi_rdata & m, e);
  endtask : axr

  // power cycle: supply cut with reset
  task automatic pwr();
    prog.supply(1'b0);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    prog.supply(1'b1);
    repeat (8) @(posedge aclk);
  endtask : pwr

  task automatic wt();
    repeat (8) @(posedge aclk);
  endtask : wt

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    aresetn = 1'b0;
    field_above_op_pin = 1'b0;
    field_below_rp_pin = 1'b0;
    fuse_sense_pin = 32'h0000_0000;
    s_axi_awvalid = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_wvalid = 1'b0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_rready = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk(32'(switch_output), 32'h1);
    repeat (4) @(posedge aclk);
    axr(sppr_pkg::ADDR_CTRL, OK, 32'hffff_ffff, sppr_pkg::CTRL_RESET);
    axr(sppr_pkg::ADDR_STATUS, OK, 32'h3f, 32'h1);
    // switch output follows the field with a fixed gap
    field_above_op_pin <= 1'b1;
    wt();
    chk(32'(switch_output), 32'h0);
    field_above_op_pin <= 1'b0;
    wt();
    chk(32'(switch_output), 32'h0);
    field_below_rp_pin <= 1'b1;
    wt();
    chk(32'(switch_output), 32'h1);
    // trial code 7 on the output register
    prog.key(2'h0);
    chk(32'(fall_time), 32'(sppr_pkg::CODE_AUTO));
    prog.mids(6);
    chk(32'(fall_time), 32'h3);
    chk(32'(switch_output), 32'h0);
    axr(sppr_pkg::ADDR_STATUS, OK, 32'hff3f, 32'h0704);
    axr(sppr_pkg::ADDR_EFFECT, OK, 32'hffff_ffff, 32'h7);
    pwr();
    chk(32'(fall_time), 32'h0);
    chk(32'(switch_output), 32'h1);
    // invert fuse gives the power-up default
    fuse_sense_pin <= 32'h4;
    pwr();
    wt();
    chk(32'(switch_output), 32'h0);
    field_above_op_pin <= 1'b1;
    wt();
    chk(32'(switch_output), 32'h1);
    field_above_op_pin <= 1'b0;
    wt();
    chk(32'(switch_output), 32'h0);
    axr(sppr_pkg::ADDR_FUSE, OK, 32'hffff_ffff, 32'h4);
    fuse_sense_pin <= 32'h0;
    pwr();
    // broken key, then supply dropout
    prog.pulse(1'b1, 6);
    prog.pulse(1'b1, 6);
    axr(sppr_pkg::ADDR_STATUS, OK, 32'h3f, 32'h1);
    prog.key(2'h2);
    chk(32'(operate_point_sign), 32'h1);
    prog.supply(1'b0);
    wt();
    prog.supply(1'b1);
    wt();
    chk(32'(operate_point_sign), 32'h0);
    // program enable off, strobe gating, bus errors
    axw(sppr_pkg::ADDR_CTRL, 32'h0, OK);
    prog.key(2'h2);
    chk(32'(operate_point_sign), 32'h0);
    axw(sppr_pkg::ADDR_CTRL, 32'h1, OK);
    s_axi_wstrb <= 4'h0;
    axw(sppr_pkg::ADDR_CTRL, 32'h0, OK);
    s_axi_wstrb <= 4'hf;
    axr(sppr_pkg::ADDR_CTRL, OK, 32'hffff_ffff, 32'h1);
    axw(8'h10, 32'h1, ERR);
    axr(8'h10, ERR, 32'hffff_ffff, 32'h0);
    axr(8'h02, ERR, 32'hffff_ffff, 32'h0);
    // blow bit 3 of the magnitude register
    prog.key(2'h1);
    prog.mids(11);
    chk(32'(operate_point_magnitude), 32'hc);
    prog.pulse(1'b1, 6);
    prog.mids(3);
    prog.blow();
    chk(blow_n, 1);
    chk(32'(blow_last), 32'hb);
    prog.blow();
    chk(blow_n, 1);
    axr(sppr_pkg::ADDR_STATUS, OK, 32'h3f, 32'h20);
    // read mode shows fuse bits on the output
    fuse_sense_pin <= 32'h400;
    pwr();
    prog.key(2'h1);
    prog.mids(11);
    prog.pulse(1'b1, 6);
    prog.pulse(1'b1, 6);
    chk(32'(switch_output), 32'h1);
    prog.mids(2);
    chk(32'(switch_output), 32'h0);
    // lock leaves only fuse checking
    fuse_sense_pin <= 32'h8;
    pwr();
    prog.key(2'h1);
    axr(sppr_pkg::ADDR_STATUS, OK, 32'h3f, 32'h1);
    chk(32'(operate_point_magnitude), 32'h0);
    prog.key(2'h3);
    chk(32'(fuse_check_sel), 32'h1);
    prog.mids(1);
    chk(32'(fuse_check_sel), 32'h2);
    test_done();
  end
endmodule : sppr_top_tb
